// ### flash_cmd_pkg.sv
// Constants shared by the quad-read wrap and page program command block
`default_nettype none
package flash_cmd_pkg;
    // Opcodes
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_SET_WRAP = 8'h77;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
    localparam logic [7:0] OP_READ_PARAM = 8'hc0;
    // Frame layout, in byte slots counted from the opcode (slot 0)
    localparam logic [3:0] ADDR_FIRST_IDX = 4'h1;
    localparam logic [3:0] ADDR_LAST_IDX = 4'h3;
    localparam logic [3:0] MODE_IDX = 4'h4;
    localparam logic [3:0] SETUP_IDX = 4'h4;
    localparam logic [3:0] PARAM_IDX = 4'h1;
    localparam logic [3:0] PP_DATA_IDX = 4'h4;
    localparam logic [3:0] NB_MAX = 4'hf;
    // Four dummy clocks in single-wire mode are two quad byte slots
    localparam logic [3:0] SPI_QIO_DUMMY_SLOTS = 4'h2;
    // Wrap setup byte fields
    localparam int WRAP_DIS_POS = 4;
    localparam int WRAP_LEN_LSB = 5;
    // Read parameter byte fields
    localparam int PARAM_DUMMY_LSB = 4;
    localparam int PARAM_WRAP_LSB = 0;
    // Reset values
    localparam logic WRAP_DIS_RESET = 1'b1;
    localparam logic [1:0] WRAP_LEN_RESET = 2'h0;
    localparam logic [1:0] DUMMY_SEL_RESET = 2'h0;
    // Page geometry
    localparam int PAGE_BYTES = 256;
    localparam int OFF_W = 8;
    localparam int ADDR_W = 24;
    // Self-timed program cycle
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_PROG_NS = 400000;
    localparam int PROG_CYCLES = (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ### flash_host_model.sv
// Host controller model: chip select, link clock and data lines
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    input wire logic [3:0] dq_i,
    output var logic sclk_o,
    output var logic cs_n_o,
    output var logic [3:0] io_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h5;
    end
    // Link clock runs only inside frames; data set in low phase, read before rise
    task automatic tick(input logic [3:0] d, output logic [3:0] q);
        io_o = d;
        #30;
        q = dq_i;
        #2 sclk_o = 1'b1;
        #32 sclk_o = 1'b0;
    endtask
    task automatic open_f();
        #3 cs_n_o = 1'b0;
    endtask
    // Released lines show the inverse so a stale value cannot pass
    task automatic close_f();
        #5 cs_n_o = 1'b1;
        io_o = ~io_o;
        #120;
    endtask
    task automatic put(input logic [7:0] b, input logic q);
        logic [3:0] x;
        if (q) begin
            tick(b[7:4], x);
            tick(b[3:0], x);
        end else begin
            for (int i = 7; i >= 0; i--) tick({3'b111, b[i]}, x);
        end
    endtask
    task automatic get(output logic [7:0] b);
        logic [3:0] h;
        logic [3:0] l;
        tick(~io_o, h);
        tick(~io_o, l);
        b = {h, l};
    endtask
    task automatic bits(input int n);
        logic [3:0] x;
        for (int i = 0; i < n; i++) tick(4'he, x);
    endtask
endmodule
`default_nettype wire

// ### flash_quad_wrap_prog.sv
// Wrap setup, quad I/O read addressing and page program of a serial flash
//
// What this block does
// - Wrap setup command enables or disables wrap for later quad I/O reads.
// - Wrapped read starts at given address and cycles its aligned section until deselect.
// - Top bit and low nibble of the wrap setup byte are ignored.
// - Wrap disable bit clear enables wrap, set disables it.
// - Length field 00/01/10/11 selects 8/16/32/64 byte sections.
// - Stored wrap setting applies to every following quad I/O read outside four-wire command mode.
// - Wrap disable bit is set at reset and soft reset.
// - Quad I/O reads never wrap in four-wire command mode.
// - Four-wire mode dummy clocks are 2/4/6/8, from read parameter command.
// - Four-wire dummy clock selection returns to 2 at reset.
// - Wrap length persists into four-wire mode; read parameter may change it.
// - Page program only taken while write enable latch is set.
// - One program writes one to 256 bytes inside one page.
// - Data past page end wraps to page start, overwriting earlier bytes.
// - Page bytes not received stay untouched.
// - Program discarded unless deselect falls on a byte boundary.
// - Busy stays high during the self-timed program cycle.
// - Write enable latch clears when the program cycle ends.
// - Program skipped when the addressed page is locked.
// - Quad I/O read rejected unless quad enable bit is set.
// - Single-wire quad I/O read has four dummy clocks.
`timescale 1ns/1ps
`default_nettype none
module flash_quad_wrap_prog #(
    parameter int PROG_CYCLES = flash_cmd_pkg::PROG_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic soft_reset_i,
    input wire logic four_wire_command_mode_i,
    input wire logic quad_enable_bit_i,
    input wire logic page_locked_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_o,
    output logic [23:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output logic prog_we_o,
    output logic [23:0] prog_addr_o,
    output logic [7:0] prog_data_o,
    output logic [23:0] lock_query_addr_o,
    output logic busy_o,
    output logic write_enable_latch_o,
    output logic wrap_disable_bit_o,
    output logic [1:0] wrap_length_field_o,
    output logic [1:0] dummy_sel_o
);
    localparam int TW = $clog2(PROG_CYCLES + 1);
    localparam logic [TW-1:0] PROG_LAST = TW'(PROG_CYCLES - 1);
    localparam int NPB = flash_cmd_pkg::PAGE_BYTES;
    localparam int OW = flash_cmd_pkg::OFF_W;

    typedef enum logic [1:0] {C_IDLE, C_EVAL, C_WRITE, C_WAIT} core_state_t;

    // Settings held in the core domain; link logic reads them only while frozen
    logic wrap_dis_q;
    logic [1:0] wrap_len_q;
    logic [1:0] dummy_q;
    logic qpi_q;
    logic qe_q;
    logic busy_q;

    // Link-side frame record, left standing after deselect for the core to read
    logic in_frame_q;
    logic [2:0] bc_q;
    logic [3:0] nb_q;
    logic [7:0] sh_q;
    logic [7:0] op_q;
    logic [23:0] pp_addr_q;
    logic [OW-1:0] off_q;
    logic pp_data_q;
    logic [7:0] setup_q;
    logic setup_seen_q;
    logic [7:0] param_q;
    logic param_seen_q;
    logic [NPB-1:0] mask_q;
    logic [7:0] buf_q [NPB];
    logic rd_act_q;
    logic nib_q;
    logic [23:0] rd_addr_q;
    logic busy_s1_q;
    logic busy_s2_q;

    function automatic logic [23:0] next_rd_addr(input logic [23:0] a, input logic wrap_on,
                                                 input logic [1:0] len);
        logic [23:0] m;
        m = {16'h0000, 8'h07} << len;
        m = m | {16'h0000, 8'h07};
        if (wrap_on) begin
            next_rd_addr = (a & ~m) | ((a + 24'h000001) & m);
        end else begin
            next_rd_addr = a + 24'h000001;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: byte assembly on the serial clock

    logic [2:0] bc_c;
    logic [3:0] nb_c;
    logic [7:0] sh_c;
    logic [7:0] op_c;
    logic quad_c;
    logic [7:0] sh_d;
    logic byte_done;
    logic [3:0] dummy_slots;
    logic wrap_on;

    always_comb begin
        bc_c = in_frame_q ? bc_q : 3'h0;
        nb_c = in_frame_q ? nb_q : 4'h0;
        sh_c = in_frame_q ? sh_q : 8'h00;
        op_c = in_frame_q ? op_q : 8'h00;
        quad_c = qpi_q || (nb_c != 4'h0 && (op_c == flash_cmd_pkg::OP_QUAD_IO_READ ||
                                            op_c == flash_cmd_pkg::OP_SET_WRAP));
        sh_d = quad_c ? {sh_c[3:0], io_i} : {sh_c[6:0], io_i[0]};
        byte_done = quad_c ? bc_c[0] : (bc_c == 3'h7);
        dummy_slots = qpi_q ? ({2'h0, dummy_q} + 4'h1)
                            : flash_cmd_pkg::SPI_QIO_DUMMY_SLOTS;
        wrap_on = !wrap_dis_q && !qpi_q;
    end

    // Frame marker; deselect is the only thing that ends a frame
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
        end
    end

    // Core busy flag, brought over before the first single-wire byte slot closes
    always_ff @(posedge sclk_i) begin
        busy_s1_q <= busy_q;
        busy_s2_q <= busy_s1_q;
    end

    always_ff @(posedge sclk_i) begin
        bc_q <= byte_done ? 3'h0 : bc_c + 3'h1;
        sh_q <= sh_d;
        if (!in_frame_q) begin
            nb_q <= 4'h0;
        end else if (byte_done && nb_q != flash_cmd_pkg::NB_MAX) begin
            nb_q <= nb_q + 4'h1;
        end
        if (byte_done && nb_c == 4'h0) begin
            op_q <= sh_d;
        end
    end

    // Wrap setup and read parameter capture
    always_ff @(posedge sclk_i) begin
        if (!in_frame_q) begin
            setup_seen_q <= 1'b0;
            param_seen_q <= 1'b0;
        end else if (byte_done) begin
            if (op_c == flash_cmd_pkg::OP_SET_WRAP && nb_c == flash_cmd_pkg::SETUP_IDX) begin
                setup_q <= sh_d;
                setup_seen_q <= 1'b1;
            end
            if (op_c == flash_cmd_pkg::OP_READ_PARAM && nb_c == flash_cmd_pkg::PARAM_IDX) begin
                param_q <= sh_d;
                param_seen_q <= 1'b1;
            end
        end
    end

    // Page program load; held off while a program walk reads the buffer
    always_ff @(posedge sclk_i) begin
        if (byte_done && nb_c == 4'h0 && !busy_s2_q) begin
            mask_q <= '0;
            pp_data_q <= 1'b0;
        end else if (byte_done && op_c == flash_cmd_pkg::OP_PAGE_PROGRAM && !busy_s2_q) begin
            if (nb_c >= flash_cmd_pkg::ADDR_FIRST_IDX && nb_c <= flash_cmd_pkg::ADDR_LAST_IDX) begin
                pp_addr_q <= {pp_addr_q[15:0], sh_d};
            end
            if (nb_c == flash_cmd_pkg::ADDR_LAST_IDX) begin
                off_q <= sh_d;
            end
            if (nb_c >= flash_cmd_pkg::PP_DATA_IDX) begin
                buf_q[off_q] <= sh_d;
                mask_q[off_q] <= 1'b1;
                off_q <= off_q + 8'h01;
                pp_data_q <= 1'b1;
            end
        end
    end

    // Quad I/O read addressing
    always_ff @(posedge sclk_i) begin
        if (!in_frame_q) begin
            rd_act_q <= 1'b0;
            nib_q <= 1'b0;
        end else if (rd_act_q) begin
            nib_q <= ~nib_q;
            if (nib_q) begin
                rd_addr_q <= next_rd_addr(rd_addr_q, wrap_on, wrap_len_q);
            end
        end else if (byte_done && op_c == flash_cmd_pkg::OP_QUAD_IO_READ) begin
            if (nb_c >= flash_cmd_pkg::ADDR_FIRST_IDX && nb_c <= flash_cmd_pkg::ADDR_LAST_IDX) begin
                rd_addr_q <= {rd_addr_q[15:0], sh_d};
            end
            if (nb_c == flash_cmd_pkg::MODE_IDX + dummy_slots && qe_q) begin
                rd_act_q <= 1'b1;
            end
        end
    end

    // Data leaves on the falling edge so the host can sample on the rising one
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            io_o <= 4'h0;
            io_oe_o <= 4'h0;
        end else begin
            io_o <= nib_q ? rd_data_i[3:0] : rd_data_i[7:4];
            io_oe_o <= {4{rd_act_q}};
        end
    end

    assign rd_addr_o = rd_addr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: frame end detection and command effects

    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic cs_rise;
    core_state_t state_q;
    logic wel_q;
    logic [15:0] page_q;
    logic [OW-1:0] idx_q;
    logic [TW-1:0] timer_q;
    logic pp_ok;

    assign cs_rise = cs_s2_q && !cs_s3_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else if (ce_i) begin
            cs_s1_q <= cs_n_i;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    // Mode bits change only while deselected, so a frame sees one setting
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            qpi_q <= 1'b0;
            qe_q <= 1'b0;
        end else if (ce_i && cs_s2_q && cs_s3_q && state_q == C_IDLE) begin
            qpi_q <= four_wire_command_mode_i;
            qe_q <= quad_enable_bit_i;
        end
    end

    // A program counts only if every byte was whole and the page is free
    assign pp_ok = op_q == flash_cmd_pkg::OP_PAGE_PROGRAM && wel_q
                   && pp_data_q && bc_q == 3'h0
                   && !page_locked_i;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= C_IDLE;
            busy_q <= 1'b0;
            idx_q <= '0;
            timer_q <= '0;
            page_q <= 16'h0000;
        end else if (ce_i) begin
            unique case (state_q)
                C_IDLE: begin
                    if (cs_rise) begin
                        state_q <= C_EVAL;
                    end
                end
                C_EVAL: begin
                    if (pp_ok) begin
                        state_q <= C_WRITE;
                        busy_q <= 1'b1;
                        page_q <= pp_addr_q[23:8];
                        idx_q <= '0;
                    end else begin
                        state_q <= C_IDLE;
                    end
                end
                C_WRITE: begin
                    idx_q <= idx_q + 8'h01;
                    if (idx_q == 8'hff) begin
                        state_q <= C_WAIT;
                        timer_q <= '0;
                    end
                end
                C_WAIT: begin
                    timer_q <= timer_q + TW'(1);
                    if (timer_q == PROG_LAST) begin
                        state_q <= C_IDLE;
                        busy_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Array write walk: only bytes loaded in this frame are touched
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prog_we_o <= 1'b0;
            prog_addr_o <= 24'h000000;
            prog_data_o <= 8'h00;
        end else if (ce_i) begin
            prog_we_o <= state_q == C_WRITE && mask_q[idx_q];
            prog_addr_o <= {page_q, idx_q};
            prog_data_o <= buf_q[idx_q];
        end
    end

    // The lock answer must be valid one cycle after deselect is seen
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            lock_query_addr_o <= 24'h000000;
        end else if (ce_i && cs_rise) begin
            lock_query_addr_o <= pp_addr_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wel_q <= 1'b0;
        end else if (ce_i) begin
            if (state_q == C_EVAL && op_q == flash_cmd_pkg::OP_WRITE_ENABLE
                && nb_q == 4'h1 && bc_q == 3'h0) begin
                wel_q <= 1'b1;
            end else if (state_q == C_WAIT && timer_q == PROG_LAST) begin
                wel_q <= 1'b0;
            end
        end
    end

    // Wrap and dummy settings
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wrap_dis_q <= flash_cmd_pkg::WRAP_DIS_RESET;
            wrap_len_q <= flash_cmd_pkg::WRAP_LEN_RESET;
            dummy_q <= flash_cmd_pkg::DUMMY_SEL_RESET;
        end else if (ce_i) begin
            if (soft_reset_i) begin
                wrap_dis_q <= flash_cmd_pkg::WRAP_DIS_RESET;
                dummy_q <= flash_cmd_pkg::DUMMY_SEL_RESET;
            end else if (state_q == C_EVAL) begin
                if (op_q == flash_cmd_pkg::OP_SET_WRAP && setup_seen_q && !qpi_q) begin
                    wrap_dis_q <= setup_q[flash_cmd_pkg::WRAP_DIS_POS];
                    wrap_len_q <= setup_q[flash_cmd_pkg::WRAP_LEN_LSB +: 2];
                end
                if (op_q == flash_cmd_pkg::OP_READ_PARAM && param_seen_q && qpi_q) begin
                    dummy_q <= param_q[flash_cmd_pkg::PARAM_DUMMY_LSB +: 2];
                    wrap_len_q <= param_q[flash_cmd_pkg::PARAM_WRAP_LSB +: 2];
                end
            end
        end
    end

    assign busy_o = busy_q;
    assign write_enable_latch_o = wel_q;
    assign wrap_disable_bit_o = wrap_dis_q;
    assign wrap_length_field_o = wrap_len_q;
    assign dummy_sel_o = dummy_q;
endmodule
`default_nettype wire

// ### flash_quad_wrap_prog_checker.sv
// Port-level assertions for the wrap setup and page program block
`timescale 1ns/1ps
`default_nettype none
module flash_quad_wrap_prog_checker #(
    parameter int PROG_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic soft_reset_i,
    input wire logic cs_n_i,
    input wire logic page_locked_i,
    input wire logic [3:0] io_oe_o,
    input wire logic prog_we_o,
    input wire logic [23:0] prog_addr_o,
    input wire logic [23:0] lock_query_addr_o,
    input wire logic busy_o,
    input wire logic write_enable_latch_o,
    input wire logic wrap_disable_bit_o,
    input wire logic [1:0] wrap_length_field_o,
    input wire logic [1:0] dummy_sel_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    int busy_cnt_q;
    // Busy length is too long for a repetition, so it is counted
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !busy_o) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 1;
        end
    end
    a_reset_values: assert property ($rose(resetn_i) |-> wrap_disable_bit_o && !busy_o
        && wrap_length_field_o == 2'h0 && dummy_sel_o == 2'h0 && !write_enable_latch_o)
        else $error("settings wrong after reset");
    a_soft_reset: assert property (soft_reset_i |-> ##[1:2]
        (wrap_disable_bit_o && dummy_sel_o == 2'h0)) else $error("soft reset not applied");
    a_busy_length: assert property ($fell(busy_o) |-> busy_cnt_q >= PROG_CYCLES + 255
        && busy_cnt_q <= PROG_CYCLES + 258) else $error("busy length wrong");
    a_wel_before_busy: assert property ($rose(busy_o) |-> write_enable_latch_o)
        else $error("program ran without write enable");
    a_wel_cleared: assert property ($fell(busy_o) |-> !write_enable_latch_o)
        else $error("write enable kept after program");
    a_write_unlocked: assert property (prog_we_o |-> busy_o && !page_locked_i)
        else $error("array write outside busy or to locked page");
    a_write_same_page: assert property (prog_we_o |->
        prog_addr_o[23:8] == lock_query_addr_o[23:8]) else $error("write left the page");
    a_oe_idle: assert property (cs_n_i && $past(cs_n_i) |-> io_oe_o == 4'h0)
        else $error("data driven while deselected");
    a_settings_hold: assert property (!$stable({wrap_disable_bit_o, wrap_length_field_o,
        dummy_sel_o}) |-> cs_n_i) else $error("settings changed inside a frame");
    c_busy: cover property ($rose(busy_o));
    c_write: cover property (prog_we_o);
    c_wrap_on: cover property ($fell(wrap_disable_bit_o));
endmodule
`default_nettype wire

// ### flash_quad_wrap_prog_end.sv
// Reserved file, holds no logic

// ### flash_quad_wrap_prog_tb_top.sv
// Self-checking bench for the wrap setup and page program block
`timescale 1ns/1ps
`default_nettype none
module flash_quad_wrap_prog_tb_top;
    logic clk = 1'b0;
    logic resetn, soft_rst, four_wire_command_mode, qe, locked, prog_we, busy, write_enable_latch, wdis;
    logic [1:0] wlen, dsel;
    logic [3:0] host_io, dut_io, oe, line;
    logic [23:0] rd_addr, prog_addr, lq_addr;
    logic [7:0] prog_data, rd_data;
    logic [7:0] mem [256];
    wire sclk, cs_n;
    int fails = 0, n_checks = 0, n_wr = 0, cyc = 0;
    initial forever #4 clk = ~clk;
    assign line = (oe & dut_io) | (~oe & host_io);
    assign rd_data = rd_addr[7:0] ^ rd_addr[15:8];
    flash_host_model i_host (.dq_i(line), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(host_io));
    flash_quad_wrap_prog #(.PROG_CYCLES(20)) i_dut (.clk_i(clk), .resetn_i(resetn),
        .ce_i(1'b1), .soft_reset_i(soft_rst), .four_wire_command_mode_i(four_wire_command_mode),
        .quad_enable_bit_i(qe), .page_locked_i(locked), .sclk_i(sclk), .cs_n_i(cs_n),
        .io_i(line), .io_o(dut_io), .io_oe_o(oe), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
        .prog_we_o(prog_we), .prog_addr_o(prog_addr), .prog_data_o(prog_data),
        .lock_query_addr_o(lq_addr), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
        .wrap_disable_bit_o(wdis), .wrap_length_field_o(wlen), .dummy_sel_o(dsel));
    always @(posedge clk) begin
        if (prog_we === 1'b1) begin
            mem[prog_addr[7:0]] <= prog_data;
            n_wr <= n_wr + 1;
        end
    end
    task automatic end_sim();
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Whole run needs well under ten thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wen();
        i_host.open_f();
        i_host.put(8'h06, 1'b0);
        i_host.close_f();
    endtask
    // Data byte k is 40h+k; extra bits end the frame off a byte boundary
    task automatic pp(input logic [23:0] a, input int n, input int xb, input logic run,
                      input logic ew);
        i_host.open_f();
        i_host.put(8'h02, 1'b0);
        for (int i = 2; i >= 0; i--) i_host.put(a[8*i+:8], 1'b0);
        for (int i = 0; i < n; i++) i_host.put(8'h40 + 8'(i), 1'b0);
        i_host.bits(xb);
        i_host.close_f();
        chk("busy", 24'(run), 24'(busy));
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk);
        @(negedge clk);
        chk("wel", 24'(ew), 24'(write_enable_latch));
    endtask
    task automatic setw(input logic [7:0] b);
        i_host.open_f();
        i_host.put(8'h77, 1'b0);
        for (int i = 0; i < 3; i++) i_host.put(8'h00, 1'b1);
        i_host.put(b, 1'b1);
        i_host.close_f();
    endtask
    // Mask m marks the address bits that cycle; all ones means linear
    task automatic rd(input logic [23:0] a, input int n, input int dmy, input logic fw,
                      input logic [23:0] m);
        logic [7:0] b;
        logic [23:0] ea;
        i_host.open_f();
        i_host.put(8'heb, fw);
        for (int i = 2; i >= 0; i--) i_host.put(a[8*i+:8], 1'b1);
        i_host.put(8'h00, 1'b1);
        i_host.bits(dmy);
        for (int i = 0; i < n; i++) begin
            i_host.get(b);
            ea = (a & ~m) | ((a + 24'(i)) & m);
            chk("rd_data", {16'h0, ea[7:0] ^ ea[15:8]}, {16'h0, b});
        end
        i_host.close_f();
    endtask
    initial begin
        {resetn, soft_rst, four_wire_command_mode, locked} = 4'h0;
        qe = 1'b1;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        chk("cfg", 24'h10, {19'h0, wdis, wlen, dsel});
        pp(24'h000310, 1, 0, 1'b0, 1'b0);
        wen();
        pp(24'h0003fe, 3, 0, 1'b1, 1'b0);
        chk("page", 24'h424041, {mem[8'h00], mem[8'hfe], mem[8'hff]});
        chk("n_wr", 24'h3, 24'(n_wr));
        wen();
        pp(24'h000500, 1, 4, 1'b0, 1'b1);
        @(negedge clk) locked = 1'b1;
        pp(24'h000600, 1, 0, 1'b0, 1'b1);
        @(negedge clk) locked = 1'b0;
        chk("n_wr", 24'h3, 24'(n_wr));
        setw(8'hcf);
        chk("wrap", 24'h2, {21'h0, wdis, wlen});
        rd(24'h001234, 16, 4, 1'b0, 24'h1f);
        setw(8'h10);
        chk("wdis", 24'h1, 24'(wdis));
        rd(24'h00123e, 4, 4, 1'b0, 24'hffffff);
        setw(8'h00);
        @(negedge clk) four_wire_command_mode = 1'b1;
        repeat (10) @(negedge clk);
        i_host.open_f();
        i_host.put(8'hc0, 1'b1);
        i_host.put(8'h31, 1'b1);
        i_host.close_f();
        chk("param", 24'h07, {19'h0, wdis, wlen, dsel});
        rd(24'h00000e, 3, 8, 1'b1, 24'hffffff);
        @(negedge clk) soft_rst = 1'b1;
        @(negedge clk) soft_rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("soft", 24'h14, {19'h0, wdis, wlen, dsel});
        end_sim();
    end
endmodule
bind flash_quad_wrap_prog flash_quad_wrap_prog_checker #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i), .cs_n_i(cs_n_i),
    .page_locked_i(page_locked_i), .io_oe_o(io_oe_o), .prog_we_o(prog_we_o),
    .prog_addr_o(prog_addr_o), .lock_query_addr_o(lock_query_addr_o), .busy_o(busy_o),
    .write_enable_latch_o(write_enable_latch_o), .wrap_disable_bit_o(wrap_disable_bit_o),
    .wrap_length_field_o(wrap_length_field_o), .dummy_sel_o(dummy_sel_o));
`default_nettype wire
